// file: rtl/tmcr_pkg.sv
package tmcr_pkg;

  // status byte codes of an inbound mailbox entry
  localparam logic [7:0] SLOT_FREE = 8'h00;
  localparam logic [7:0] SLOT_BLOCK_REQ = 8'h10;

  // field positions inside entry byte 1
  localparam int B1_INIT_LSB = 5;
  localparam int B1_RECV_BIT = 4;
  localparam int B1_SEND_BIT = 3;
  localparam int B1_LUN_LSB = 0;

  // byte lanes of the 32-bit entry word, status byte first in memory
  localparam int WORD_B0_LSB = 24;
  localparam int WORD_B1_LSB = 16;
  localparam int WORD_B2_LSB = 8;
  localparam int WORD_B3_LSB = 0;

  // entry geometry and reset values
  localparam int ENTRY_BYTES = 4;
  localparam logic RST_FLAG = 1'b0;

  // target command as handed over by the bus-facing sequencer
  typedef struct packed {
    logic [2:0] initId;
    logic [2:0] lun;
    logic isSend;
    logic isRecv;
    logic [7:0] cdbByte2;
    logic [7:0] cdbByte3;
    logic blockHeld;
  } tmcr_cmd_t;

  // states of the posting sequence
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEEK,
    ST_READ,
    ST_PUT,
    ST_WRITE
  } tmcr_state_t;

endpackage

// file: rtl/tmcr_mbox.sv
`timescale 1ns/1ps

// Notes on behaviour
// - request entry only for target command lacking block
// - status byte of request is 10h
// - post only when unit mask enables unit
// - initiator address in byte 1 bits 7-5
// - unit address in byte 1 bits 2-0
// - bit 3 for send, bit 4 receive
// - bytes 2-3 copy command bytes 2-3
// - bus released once command taken in
// - disabled unit gives check condition, no entry
// - next sense reports invalid unit error
// - idle interrupts: set full, any, line
// - full still set: no further notification
// - other interrupts pending: defer full flag
// - read status byte to find free entry
module tmcr_mbox #(
  parameter int ENTRIES = 8,
  parameter int ADDR_W = 24,
  parameter logic [23:0] INBOUND_BASE = 24'h000000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // target command from the bus sequencer
  input wire logic cmdValid,
  input wire tmcr_pkg::tmcr_cmd_t cmd,
  output logic cmdReady,
  output logic busRelease,
  output logic checkCond,
  // unit enable mask, one bit per logical unit
  input wire logic [7:0] lunMask,
  // request sense handling
  input wire logic requestSense,
  output logic senseValid,
  output logic senseInvalidLun,
  // host memory port to the inbound mailbox area
  output logic memReq,
  output logic memWe,
  output logic [ADDR_W-1:0] memAddr,
  output logic [31:0] memWdata,
  input wire logic memAck,
  input wire logic [7:0] memRdata,
  // interrupt flags
  input wire logic otherIntPending,
  input wire logic intClear,
  output logic inboundFull,
  output logic anyInt,
  output logic irq
);
  import tmcr_pkg::*;

  localparam int PTR_W = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

  // posting sequence, one inbound entry per accepted command:
  //   idle  -> seek   command taken, bus released
  //   seek  -> read   status byte fetch issued
  //   read  -> put    status byte showed a free entry
  //   read  -> seek   entry busy, step to the next index
  //   put   -> write  whole entry issued as one word
  //   write -> idle   acked; notification left to the wait flag
  // only the status byte is read back; the rest of a busy entry is the host's
  // limitation: with every entry busy the scan never gives up, so a
  // host that stops freeing entries stalls the command side as well

  typedef struct packed {
    // sequencing and the command being posted
    tmcr_state_t st;
    logic [PTR_W-1:0] ptr;
    tmcr_cmd_t held;
    // image of the memory port
    logic memReq;
    logic memWe;
    logic [ADDR_W-1:0] memAddr;
    logic [31:0] memWdata;
    // notification state and interrupt flags
    logic noteWait;
    logic inboundFull;
    logic anyInt;
    // target side pulses and sense answer
    logic busRelease;
    logic checkCond;
    logic senseBad;
    logic senseValid;
    logic senseInvalidLun;
  } tmcr_regs_t;

  tmcr_regs_t s;
  tmcr_regs_t next_s;

  // byte address of entry idx in the inbound area
  function automatic logic [ADDR_W-1:0] entryAddr(input logic [PTR_W-1:0] idx);
    logic [ADDR_W-1:0] off;
    off = ADDR_W'(idx) * ADDR_W'(ENTRY_BYTES);
    // base may sit anywhere; entries are packed four bytes apart
    return ADDR_W'(INBOUND_BASE) + off;
  endfunction

  // round-robin successor, wrapping after the last entry
  function automatic logic [PTR_W-1:0] nextPtr(input logic [PTR_W-1:0] idx);
    logic [PTR_W-1:0] r;
    r = (idx == PTR_W'(ENTRIES - 1)) ? '0 : PTR_W'(idx + 1'b1);
    return r;
  endfunction

  // assemble the command-block-required entry word
  function automatic logic [31:0] reqWord(input tmcr_cmd_t c);
    logic [31:0] w;
    logic [7:0] b1;
    b1 = 8'h00;
    b1[B1_INIT_LSB +: 3] = c.initId;
    b1[B1_SEND_BIT] = c.isSend;
    b1[B1_RECV_BIT] = c.isRecv;
    b1[B1_LUN_LSB +: 3] = c.lun;
    w = 32'h00000000;
    w[WORD_B0_LSB +: 8] = SLOT_BLOCK_REQ;
    w[WORD_B1_LSB +: 8] = b1;
    w[WORD_B2_LSB +: 8] = c.cdbByte2;
    w[WORD_B3_LSB +: 8] = c.cdbByte3;
    return w;
  endfunction

  logic cmdIsReq;
  logic unitOn;

  // only send or receive with no block on hand
  // commands with both or neither direction bit are not ours to answer
  assign cmdIsReq = (cmd.isSend ^ cmd.isRecv) && !cmd.blockHeld;

  // unit mask lookup for the offered command
  // the mask is read live, so a change takes effect with the next command
  assign unitOn = lunMask[cmd.lun];

  // a single command in flight; the sequencer stalls while a post runs,
  // which keeps the held copy from being overwritten mid-post
  assign cmdReady = (s.st == ST_IDLE);

  // next-state logic for the whole block
  always_comb
  begin
    next_s = s;
    next_s.busRelease = 1'b0;
    next_s.checkCond = 1'b0;
    next_s.senseValid = 1'b0;

    // sense answer consumes the invalid unit mark
    if (requestSense)
    begin
      next_s.senseValid = 1'b1;
      next_s.senseInvalidLun = s.senseBad;
      next_s.senseBad = 1'b0;
    end

    case (s.st)
      ST_IDLE:
      begin
        if (cmdValid && cmdIsReq)
        begin
          // unit must be enabled to post
          if (unitOn)
          begin
            next_s.held = cmd;
            // disconnect while the block is awaited
            next_s.busRelease = 1'b1;
            next_s.st = ST_SEEK;
          end
          else
          begin
            next_s.checkCond = 1'b1;
            // set placed after the sense clear so it wins
            next_s.senseBad = 1'b1;
          end
        end
      end
      ST_SEEK:
      begin
        next_s.memReq = 1'b1;
        next_s.memWe = 1'b0;
        next_s.memAddr = entryAddr(s.ptr);
        next_s.st = ST_READ;
      end
      ST_READ:
      begin
        if (memAck)
        begin
          next_s.memReq = 1'b0;
          // any nonzero status marks a busy entry, whatever its code
          if (memRdata == SLOT_FREE)
          begin
            next_s.st = ST_PUT;
          end
          else
          begin
            // keep the request and try the next entry
            next_s.ptr = nextPtr(s.ptr);
            next_s.st = ST_SEEK;
          end
        end
      end
      ST_PUT:
      begin
        // whole entry in one word so the status never leads its data
        next_s.memReq = 1'b1;
        next_s.memWe = 1'b1;
        next_s.memAddr = entryAddr(s.ptr);
        next_s.memWdata = reqWord(s.held);
        next_s.st = ST_WRITE;
      end
      ST_WRITE:
      begin
        if (memAck)
        begin
          next_s.memReq = 1'b0;
          next_s.memWe = 1'b0;
          next_s.ptr = nextPtr(s.ptr);
          next_s.noteWait = 1'b1;
          next_s.st = ST_IDLE;
        end
      end
      default:
      begin
        next_s.st = ST_IDLE;
      end
    endcase

    // host clear of the interrupt flags
    if (intClear)
    begin
      next_s.inboundFull = 1'b0;
      next_s.anyInt = 1'b0;
    end

    // notification after a stored entry; the set comes last and wins.
    // the note resolves one cycle after the write ack, so a host clear
    // in that cycle cannot swallow the news of the new entry
    if (s.noteWait)
    begin
      if (s.inboundFull && !intClear)
      begin
        // already flagged, nothing more to say
        next_s.noteWait = 1'b0;
      end
      else if (otherIntPending)
      begin
        // wait until other sources are cleared
        // keeps a clear meant for another source from hiding this one
        next_s.noteWait = 1'b1;
      end
      else
      begin
        // raise full, any and the line
        next_s.inboundFull = 1'b1;
        next_s.anyInt = 1'b1;
        next_s.noteWait = 1'b0;
      end
    end
  end

  // state register; reset loads constants only
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s <= '0;
      s.st <= ST_IDLE;
      s.inboundFull <= RST_FLAG;
      s.anyInt <= RST_FLAG;
    end
    else
    begin
      s <= next_s;
    end
  end

  // target side pulses and sense answer, straight from the state
  assign busRelease = s.busRelease;
  assign checkCond = s.checkCond;
  assign senseValid = s.senseValid;
  assign senseInvalidLun = s.senseInvalidLun;

  // memory port, registered so it stands until the ack
  assign memReq = s.memReq;
  assign memWe = s.memWe;
  assign memAddr = s.memAddr;
  assign memWdata = s.memWdata;

  // interrupt flags
  assign inboundFull = s.inboundFull;
  assign anyInt = s.anyInt;
  // the line follows the any-interrupt flag
  assign irq = s.anyInt;

endmodule

// file: testbench/tmcr_mbox_properties.sv
`timescale 1ns/1ps
module tmcr_mbox_properties (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // command side
  input wire logic cmdValid,
  input wire tmcr_pkg::tmcr_cmd_t cmd,
  input wire logic cmdReady,
  input wire logic busRelease,
  input wire logic checkCond,
  input wire logic [7:0] lunMask,
  input wire logic requestSense,
  input wire logic senseValid,
  // memory and flags
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [31:0] memWdata,
  input wire logic otherIntPending,
  input wire logic intClear,
  input wire logic inboundFull,
  input wire logic anyInt,
  input wire logic irq
);
  import tmcr_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic take;
  // a command the block has to act on
  assign take = cmdValid && cmdReady && (cmd.isSend ^ cmd.isRecv) && !cmd.blockHeld;
  a_unit_answer: assert property (take |=> busRelease == $past(lunMask[cmd.lun])
    && checkCond == !busRelease) else $error("unit answer wrong");
  a_held_ignored: assert property (cmdValid && cmdReady && cmd.blockHeld
    |=> !busRelease && !checkCond) else $error("held block answered");
  a_status_code: assert property (memReq && memWe
    |-> memWdata[31:24] == SLOT_BLOCK_REQ) else $error("bad status byte");
  a_reject_quiet: assert property (checkCond |-> !memReq) else $error("reject posted");
  a_sense_answer: assert property (requestSense |=> senseValid) else $error("no sense");
  a_flags_tied: assert property (irq == anyInt && anyInt == inboundFull)
    else $error("flags differ");
  a_full_holds: assert property (inboundFull && !intClear |=> inboundFull)
    else $error("full flag lost");
  a_full_defers: assert property (!inboundFull && otherIntPending |=> !inboundFull)
    else $error("full flag early");
endmodule
bind tmcr_mbox tmcr_mbox_properties u_props (.mclk, .reset, .cmdValid, .cmd, .cmdReady,
  .busRelease, .checkCond, .lunMask, .requestSense, .senseValid, .memReq, .memWe,
  .memWdata, .otherIntPending, .intClear, .inboundFull, .anyInt, .irq);

// file: testbench/tmcr_mem_model.sv
`timescale 1ns/1ps
module tmcr_mem_model (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // memory port
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [23:0] memAddr,
  input wire logic [31:0] memWdata,
  output logic memAck,
  output logic [7:0] memRdata,
  // host side: free one entry; block size prepared for the last request
  input wire logic hostFree,
  input wire logic [2:0] hostFreeIdx,
  output logic [16:0] blockLen
);
  logic [7:0] stat [8];
  // random wait; read data scrambles outside the ack cycle
  always @(posedge mclk)
  begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (reset)
    begin
      memRdata <= 8'h00;
      blockLen <= 17'h00000;
      foreach (stat[i]) stat[i] <= 8'h00;
    end
    else
    begin
      // host returns an entry by writing 00h to its status
      if (hostFree)
        stat[hostFreeIdx] <= 8'h00;
      if (memReq && !memAck && $urandom_range(2) == 0)
      begin
        memAck <= 1'b1;
        if (memWe)
        begin
          stat[memAddr[4:2]] <= memWdata[31:24];
          // room for the hint plus up to 256 more bytes
          blockLen <= 17'(memWdata[15:0]) + 17'd256;
        end
        else
          memRdata <= stat[memAddr[4:2]];
      end
    end
  end
endmodule

// file: testbench/test_target_mode_ccb_request_mailbox.sv
`timescale 1ns/1ps
module test_target_mode_ccb_request_mailbox;
  import tmcr_pkg::*;
  logic mclk = 0, reset = 1, cmdValid = 0, requestSense = 0, otherIntPending = 0, intClear = 0;
  logic [7:0] lunMask = 8'h7f;
  tmcr_cmd_t cmd = '0;
  logic cmdReady, busRelease, checkCond, senseValid, senseInvalidLun, memReq, memWe, memAck;
  logic inboundFull, anyInt, irq, hostFree = 0;
  logic [2:0] hostFreeIdx = 3'h0;
  logic [16:0] blockLen;
  tmcr_cmd_t lastCmd = '0;
  logic [23:0] memAddr;
  logic [31:0] memWdata;
  logic [7:0] memRdata;
  logic [55:0] expq [$];
  int fails = 0, n_compared = 0;
  always #10 mclk = ~mclk;
  tmcr_mbox dut (.mclk, .reset, .cmdValid, .cmd, .cmdReady, .busRelease, .checkCond,
    .lunMask, .requestSense, .senseValid, .senseInvalidLun, .memReq, .memWe, .memAddr,
    .memWdata, .memAck, .memRdata, .otherIntPending, .intClear, .inboundFull, .anyInt, .irq);
  tmcr_mem_model mem (.mclk, .reset, .memReq, .memWe, .memAddr, .memWdata, .memAck,
    .memRdata, .hostFree, .hostFreeIdx, .blockLen);
  task check(input logic [55:0] seen, input logic [55:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error time %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // bounded wait for the block to go idle
  task idle;
    int i;
    repeat (2) @(negedge mclk);
    for (i = 0; i < 400 && !(cmdReady && !memReq); i++)
      @(negedge mclk);
    if (i == 400)
    begin
      fails++;
      give_verdict();
    end
  endtask
  // offer a command on unit l and note the entry expected for address a
  task offer(input logic [2:0] l, input logic held, input logic [23:0] a);
    tmcr_cmd_t c;
    @(negedge mclk);
    c = 25'($urandom);
    c.lun = l;
    c.isRecv = !c.isSend;
    c.blockHeld = held;
    cmd = c;
    lastCmd = c;
    cmdValid = 1'b1;
    if (lunMask[l] && !held)
      expq.push_back({a, SLOT_BLOCK_REQ, c.initId, c.isRecv, c.isSend, c.lun,
        c.cdbByte2, c.cdbByte3});
    @(negedge mclk);
    cmdValid = 1'b0;
  endtask
  // each stored entry against the oldest note
  always @(posedge mclk)
    if (memReq && memWe && memAck)
      check({memAddr, memWdata}, expq.size() ? expq.pop_front() : 56'h0);
  initial
  begin
    void'($urandom(32'hd253fbe0));
    repeat (10) @(negedge mclk);
    reset = 1'b0;
    otherIntPending = 1'b1;
    offer(3'h0, 1'b0, 24'h0);
    idle();
    check(56'(blockLen), 56'({lastCmd.cdbByte2, lastCmd.cdbByte3}) + 56'd256);
    repeat (4) @(negedge mclk);
    check(56'(inboundFull), 56'h0);
    otherIntPending = 1'b0;
    repeat (3) @(negedge mclk);
    check(56'({inboundFull, anyInt, irq}), 56'h7);
    $display("interrupt test done");
    // host already supplied this block, so no request may follow
    offer(3'h1, 1'b1, 24'h0);
    for (int k = 1; k < 8; k++)
    begin
      offer(3'(k - 1), 1'b0, 24'(4 * k));
      idle();
    end
    check(56'(inboundFull), 56'h1);
    // let the last entry's note resolve before the host clears
    @(negedge mclk);
    intClear = 1'b1;
    @(negedge mclk);
    intClear = 1'b0;
    check(56'(inboundFull), 56'h0);
    $display("fill test done");
    offer(3'h7, 1'b0, 24'h0);
    check(56'(checkCond), 56'h1);
    requestSense = 1'b1;
    @(negedge mclk);
    requestSense = 1'b0;
    check(56'({senseValid, senseInvalidLun}), 56'h3);
    $display("reject test done");
    offer(3'h2, 1'b0, 24'hc);
    repeat (30) @(negedge mclk);
    check(56'(expq.size()), 56'h1);
    hostFreeIdx = 3'h3;
    hostFree = 1'b1;
    @(negedge mclk);
    hostFree = 1'b0;
    idle();
    check(56'(expq.size()), 56'h0);
    $display("full area test done");
    give_verdict();
  end
endmodule
